// ### include/ces_regs.vh
// Register map, field positions and reset values of the charger event block
`ifndef CES_REGS_VH
`define CES_REGS_VH

// Register indices; byte address is four times the index
`define CES_IDX_STATUS      6'h19
`define CES_IDX_MASK        6'h21
`define CES_IDX_LEVEL       6'h22

// Status, mask and level bit positions
`define CES_BIT_VBAT_LOW    0
`define CES_BIT_VBAT_MID    1
`define CES_BIT_VBAT_HIGH   2
`define CES_BIT_FAST_RDY    9
`define CES_BIT_BEGUN       10
`define CES_BIT_FINAL       11
`define CES_BIT_TIMEOUT     12
`define CES_BIT_BATT_FAIL   13

// Bits that carry a charger event; the rest are reserved and read zero in status and level
`define CES_IMPL_BITS       16'h3e07

// Reset values
`define CES_RST_STATUS      16'h0000
`define CES_RST_MASK        16'hffff
`define CES_RST_FLAG        1'b0

// Cycles after reset before edge detection is trusted
`define CES_PRIME_CYCLES    2'h3

`endif

// ### hdl/ces_top.v
// Charger event status and mask registers with APB access and interrupt
//
// The APB register port was decided locally.
`timescale 1ns/10ps
//
// How it works
// - Safety timer expiry rising edge sets status bit 12.
// - Final charge stage rising edge sets status bit 11.
// - Charge start rising edge sets status bit 10.
// - Fast charge ready rising edge sets status bit 9.
// - Battery below 3.9 threshold rising edge sets status bit 2.
// - Battery below 3.1 threshold rising edge sets status bit 1.
// - Battery below 2.85 threshold rising edge sets a status flag.
// - Flags set only on low-to-high transitions of their source.
// - Reading the status register clears the flags it returned.
// - Mask register has sixteen bits aligned with the status bits.
// - A mask bit of one blocks its flag from the interrupt.
// - Mask register lives at index 21h, readable and writable.
// - Battery failure rising edge sets status bit 13.
`include "ces_regs.vh"

// One charger condition: two-flop synchroniser, edge detector, sticky flag
module ces_flag_cell #(
  parameter RST_FLAG = 1'b0
) (
  clk,
  rst_b,
  cond,
  primed,
  clr,
  flag_q,
  level_q
);

  input  wire clk;
  input  wire rst_b;
  input  wire cond;
  input  wire primed;
  input  wire clr;
  output reg  flag_q;
  output reg  level_q;

  reg  sync1_q;
  reg  hist_q;
  reg  flag_d;
  wire rise;

  // Only a low-to-high change counts; a steady high sets nothing more
  assign rise = level_q & ~hist_q & primed;

  // A new edge wins over a clear in the same cycle
  always @* begin
    flag_d = flag_q;
    if (clr) begin
      flag_d = 1'b0;
    end
    if (rise) begin
      flag_d = 1'b1;
    end
  end

  // The condition comes from the analog side, so two flops before any use
  always @(posedge clk) begin
    if (!rst_b) begin
      sync1_q <= 1'b0;
      level_q <= 1'b0;
      hist_q  <= 1'b0;
      flag_q  <= RST_FLAG;
    end else begin
      sync1_q <= cond;
      level_q <= sync1_q;
      hist_q  <= level_q;
      flag_q  <= flag_d;
    end
  end

endmodule

module ces_top #(
  parameter ADDR_W = 8
) (
  clk,
  rst_b,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  pstrb,
  prdata,
  pready,
  pslverr,
  chg_timeout_cond,
  chg_final_cond,
  chg_begun_cond,
  chg_fast_rdy_cond,
  vbat_lt_high_cond,
  vbat_lt_mid_cond,
  vbat_lt_low_cond,
  batt_fail_cond,
  charger_irq_out
);

  input  wire              clk;
  input  wire              rst_b;
  input  wire              psel;
  input  wire              penable;
  input  wire              pwrite;
  input  wire [ADDR_W-1:0] paddr;
  input  wire [31:0]       pwdata;
  input  wire [3:0]        pstrb;
  output wire [31:0]       prdata;
  output wire              pready;
  output wire              pslverr;
  input  wire              chg_timeout_cond;
  input  wire              chg_final_cond;
  input  wire              chg_begun_cond;
  input  wire              chg_fast_rdy_cond;
  input  wire              vbat_lt_high_cond;
  input  wire              vbat_lt_mid_cond;
  input  wire              vbat_lt_low_cond;
  input  wire              batt_fail_cond;
  output wire              charger_irq_out;

  reg  [1:0]  prime_q;
  reg  [15:0] mask_q;
  reg  [15:0] mask_d;
  reg  [31:0] prdata_q;
  reg  [31:0] rdata_d;
  reg         irq_q;
  reg         hit_d;
  reg  [15:0] wr_bits;

  wire [5:0]  word_idx;
  wire        setup_ph;
  wire        access_ph;
  wire        is_status;
  wire        is_mask;
  wire        is_level;
  wire        primed;
  wire [15:0] status_vec;
  wire [15:0] level_vec;
  wire [15:0] rd_clr;
  wire [15:0] wr_clr;
  wire [15:0] clr_vec;

  // Edge detection waits until the synchronisers hold real samples
  always @(posedge clk) begin
    if (!rst_b) begin
      prime_q <= 2'h0;
    end else if (prime_q != `CES_PRIME_CYCLES) begin
      prime_q <= prime_q + 2'h1;
    end
  end

  // A condition already high at reset release is not an edge
  assign primed = (prime_q == `CES_PRIME_CYCLES);

  // Reserved positions hold no flag and read zero
  assign status_vec[15:14] = 2'h0;
  assign status_vec[8:3]   = 6'h00;
  assign level_vec[15:14]  = 2'h0;
  assign level_vec[8:3]    = 6'h00;
  assign clr_vec           = rd_clr | wr_clr;

  // One cell per charger condition; the status bits are their flags

  // Safety timer expiry
  ces_flag_cell #(
    .RST_FLAG (`CES_RST_FLAG)
  ) i_ces_flag_cell_timeout (
    .clk     (clk),
    .rst_b   (rst_b),
    .cond    (chg_timeout_cond),
    .primed  (primed),
    .clr     (clr_vec[`CES_BIT_TIMEOUT]),
    .flag_q  (status_vec[`CES_BIT_TIMEOUT]),
    .level_q (level_vec[`CES_BIT_TIMEOUT])
  );

  // Final charge stage
  ces_flag_cell #(
    .RST_FLAG (`CES_RST_FLAG)
  ) i_ces_flag_cell_final (
    .clk     (clk),
    .rst_b   (rst_b),
    .cond    (chg_final_cond),
    .primed  (primed),
    .clr     (clr_vec[`CES_BIT_FINAL]),
    .flag_q  (status_vec[`CES_BIT_FINAL]),
    .level_q (level_vec[`CES_BIT_FINAL])
  );

  // Charge start
  ces_flag_cell #(
    .RST_FLAG (`CES_RST_FLAG)
  ) i_ces_flag_cell_begun (
    .clk     (clk),
    .rst_b   (rst_b),
    .cond    (chg_begun_cond),
    .primed  (primed),
    .clr     (clr_vec[`CES_BIT_BEGUN]),
    .flag_q  (status_vec[`CES_BIT_BEGUN]),
    .level_q (level_vec[`CES_BIT_BEGUN])
  );

  // Ready for fast charge
  ces_flag_cell #(
    .RST_FLAG (`CES_RST_FLAG)
  ) i_ces_flag_cell_fast_rdy (
    .clk     (clk),
    .rst_b   (rst_b),
    .cond    (chg_fast_rdy_cond),
    .primed  (primed),
    .clr     (clr_vec[`CES_BIT_FAST_RDY]),
    .flag_q  (status_vec[`CES_BIT_FAST_RDY]),
    .level_q (level_vec[`CES_BIT_FAST_RDY])
  );

  // Battery below the high threshold
  ces_flag_cell #(
    .RST_FLAG (`CES_RST_FLAG)
  ) i_ces_flag_cell_vbat_high (
    .clk     (clk),
    .rst_b   (rst_b),
    .cond    (vbat_lt_high_cond),
    .primed  (primed),
    .clr     (clr_vec[`CES_BIT_VBAT_HIGH]),
    .flag_q  (status_vec[`CES_BIT_VBAT_HIGH]),
    .level_q (level_vec[`CES_BIT_VBAT_HIGH])
  );

  // Battery below the middle threshold
  ces_flag_cell #(
    .RST_FLAG (`CES_RST_FLAG)
  ) i_ces_flag_cell_vbat_mid (
    .clk     (clk),
    .rst_b   (rst_b),
    .cond    (vbat_lt_mid_cond),
    .primed  (primed),
    .clr     (clr_vec[`CES_BIT_VBAT_MID]),
    .flag_q  (status_vec[`CES_BIT_VBAT_MID]),
    .level_q (level_vec[`CES_BIT_VBAT_MID])
  );

  // Battery below the low threshold
  ces_flag_cell #(
    .RST_FLAG (`CES_RST_FLAG)
  ) i_ces_flag_cell_vbat_low (
    .clk     (clk),
    .rst_b   (rst_b),
    .cond    (vbat_lt_low_cond),
    .primed  (primed),
    .clr     (clr_vec[`CES_BIT_VBAT_LOW]),
    .flag_q  (status_vec[`CES_BIT_VBAT_LOW]),
    .level_q (level_vec[`CES_BIT_VBAT_LOW])
  );

  // Battery failure
  ces_flag_cell #(
    .RST_FLAG (`CES_RST_FLAG)
  ) i_ces_flag_cell_batt_fail (
    .clk     (clk),
    .rst_b   (rst_b),
    .cond    (batt_fail_cond),
    .primed  (primed),
    .clr     (clr_vec[`CES_BIT_BATT_FAIL]),
    .flag_q  (status_vec[`CES_BIT_BATT_FAIL]),
    .level_q (level_vec[`CES_BIT_BATT_FAIL])
  );

  // APB decode; paddr[1:0] are ignored, each register is one word
  assign word_idx  = paddr[7:2];
  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign is_status = (word_idx == `CES_IDX_STATUS);
  assign is_mask   = (word_idx == `CES_IDX_MASK);
  assign is_level  = (word_idx == `CES_IDX_LEVEL);

  // Zero wait states: read data is captured in the setup cycle
  assign pready  = access_ph;
  assign pslverr = access_ph & ~hit_d;
  assign prdata  = prdata_q;

  // Unmapped addresses read zero and raise an error
  always @* begin
    hit_d   = is_status | is_mask | is_level;
    rdata_d = 32'h00000000;
    if (is_status) begin
      rdata_d = {16'h0000, status_vec};
    end else if (is_mask) begin
      rdata_d = {16'h0000, mask_q};
    end else if (is_level) begin
      rdata_d = {16'h0000, level_vec};
    end
  end

  // Byte lanes 0 and 1 hold the sixteen register bits
  always @* begin
    wr_bits = 16'h0000;
    if (pstrb[0]) begin
      wr_bits[7:0] = 8'hff;
    end
    if (pstrb[1]) begin
      wr_bits[15:8] = 8'hff;
    end
  end

  // Clear only what the host actually saw, so a later edge survives
  assign rd_clr = (access_ph & ~pwrite & is_status) ?
                  prdata_q[15:0] : 16'h0000;
  // Writing ones also clears, for drivers that acknowledge by write
  assign wr_clr = (access_ph & pwrite & is_status) ?
                  (pwdata[15:0] & wr_bits) : 16'h0000;

  // A mask bit of one keeps its flag away from the interrupt
  always @* begin
    mask_d = mask_q;
    if (access_ph & pwrite & is_mask) begin
      mask_d = (mask_q & ~wr_bits) | (pwdata[15:0] & wr_bits);
    end
  end

  // Bus-side registers; the flags themselves live in the cells
  always @(posedge clk) begin
    if (!rst_b) begin
      mask_q   <= `CES_RST_MASK;
      prdata_q <= 32'h00000000;
      irq_q    <= 1'b0;
    end else begin
      mask_q   <= mask_d;
      // Capture in setup so the clear sees exactly what was returned
      if (setup_ph & ~pwrite) begin
        prdata_q <= rdata_d;
      end
      // Registered so the interrupt pin never glitches on decode
      irq_q <= |(status_vec & ~mask_q);
    end
  end

  // Level output, high while any unmasked flag is set
  assign charger_irq_out = irq_q;

endmodule

// ### verification/ces_top_asserts.sv
// Port checker of the charger event block
`timescale 1ns/10ps
`include "ces_regs.vh"
module ces_top_asserts #(
  parameter ADDR_W = 8
) (
  input wire              clk,
  input wire              rst_b,
  input wire              psel,
  input wire              penable,
  input wire              pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0]       prdata,
  input wire              pready,
  input wire              pslverr,
  input wire              charger_irq_out
);
  wire       acc = psel && penable;
  wire [5:0] idx = paddr[7:2];
  wire       rd = acc && !pwrite;
  wire       st = idx == `CES_IDX_STATUS;
  wire       mk = idx == `CES_IDX_MASK;
  wire       map = st || mk || idx == `CES_IDX_LEVEL;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_zero_wait: assert property (pready == acc)
    else $error("pready wrong");
  a_upper_zero: assert property (rd |-> prdata[31:16] == 16'h0000)
    else $error("upper data set");
  a_mask_ok: assert property (acc && mk |-> !pslverr)
    else $error("mask error");
  a_status_ok: assert property (acc && st |-> !pslverr)
    else $error("status error");
  a_bad_addr: assert property (rd && !map |-> pslverr && prdata == 0)
    else $error("unmapped read");
  a_status_rsvd: assert property (rd && st |->
    (prdata[15:0] & ~`CES_IMPL_BITS) == 16'h0000)
    else $error("reserved bit set");
  a_irq_fall: assert property ($fell(charger_irq_out) |-> $past(acc, 2))
    else $error("irq fell alone");
  a_irq_reset: assert property ($rose(rst_b) |-> !charger_irq_out)
    else $error("irq after reset");
endmodule
bind ces_top ces_top_asserts #(.ADDR_W(ADDR_W)) i_ces_top_asserts (
  .clk, .rst_b, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .charger_irq_out);

// ### verification/ces_host.sv
// Host model issuing APB transfers
`timescale 1ns/10ps
module ces_host (
  input  wire         clk,
  input  wire         pready,
  input  wire  [31:0] prdata,
  input  wire         pslverr,
  output logic        psel,
  output logic        penable,
  output logic        pwrite,
  output logic [7:0]  paddr,
  output logic [31:0] pwdata
);
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released bus must not look like the last request
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge clk);
  endtask
endmodule

// ### verification/tb_ces_top.sv
// Self-checking bench of the charger event block
`timescale 1ns/10ps
`include "ces_regs.vh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
  n_mismatch++; $display("Error %0t %h %h", $time, a, b); end end
module tb_ces_top;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  cond = 8'h00;
  logic        psel, penable, pwrite, pready, pslverr, irq, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          cyc = 0;
  logic [15:0] row [8] = '{16'h1000, 16'h0800, 16'h0400, 16'h0200,
                           16'h0004, 16'h0002, 16'h0001, 16'h2000};
  localparam logic [7:0] ST = {`CES_IDX_STATUS, 2'b00};
  localparam logic [7:0] MK = {`CES_IDX_MASK, 2'b00};
  always #2.5 clk = ~clk;
  ces_top i_ces_top (.clk, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr,
    .chg_timeout_cond(cond[0]), .chg_final_cond(cond[1]),
    .chg_begun_cond(cond[2]), .chg_fast_rdy_cond(cond[3]),
    .vbat_lt_high_cond(cond[4]), .vbat_lt_mid_cond(cond[5]),
    .vbat_lt_low_cond(cond[6]), .batt_fail_cond(cond[7]),
    .charger_irq_out(irq));
  ces_host i_ces_host (.clk, .pready, .prdata, .pslverr, .psel, .penable,
    .pwrite, .paddr, .pwdata);
  task automatic stop_test();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_mismatch++;
      stop_test();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    i_ces_host.xfer(1'b0, MK, 32'h0, r, e);
    `CHK(r, 32'h0000ffff)
    for (int i = 0; i < 8; i++) begin
      cond[i] <= 1'b1;
      repeat (6) @(posedge clk);
      `CHK(irq, 1'b0)
      i_ces_host.xfer(1'b0, ST, 32'h0, r, e);
      `CHK(r, {16'h0000, row[i]})
      i_ces_host.xfer(1'b0, ST, 32'h0, r, e);
      `CHK(r, 32'h0)
      cond[i] <= 1'b0;
      repeat (3) @(posedge clk);
    end
    cond[7] <= 1'b1;
    i_ces_host.xfer(1'b1, MK, 32'h0000dfff, r, e);
    repeat (4) @(posedge clk);
    `CHK(irq, 1'b1)
    i_ces_host.xfer(1'b0, MK, 32'h0, r, e);
    `CHK(r, 32'h0000dfff)
    i_ces_host.xfer(1'b1, MK, 32'h0000ffff, r, e);
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b0)
    i_ces_host.xfer(1'b0, ST, 32'h0, r, e);
    `CHK(r, 32'h00002000)
    i_ces_host.xfer(1'b0, 8'h00, 32'h0, r, e);
    `CHK({e, r}, {1'b1, 32'h0})
    i_ces_host.xfer(1'b0, {`CES_IDX_LEVEL, 2'b00}, 32'h0, r, e);
    `CHK({e, r}, {1'b0, 32'h00002000})
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    `CHK(irq, 1'b0)
    stop_test();
  end
endmodule
